// ==== dpsm_pkg.sv ====
// dpsm_pkg: constants and types for the drive power state machine
// assumes a 100 MHz i_mclk; no registers reachable by software
package dpsm_pkg;
	// command codes presented on i_cmd with i_cmd_valid
	typedef enum logic [3:0] {
		DPSM_CMD_NONE = 4'h0,
		DPSM_CMD_SHUTDOWN = 4'h1,
		DPSM_CMD_SWITCH_ON = 4'h2,
		DPSM_CMD_DIS_VOLT = 4'h3,
		DPSM_CMD_QUICK_STOP = 4'h4,
		DPSM_CMD_DIS_OP = 4'h5,
		DPSM_CMD_EN_OP = 4'h6,
		DPSM_CMD_FAULT_RESET = 4'h7
	} dpsm_cmd_t;

	// one-hot state codes
	typedef enum logic [8:0] {
		DPSM_NOT_READY = 9'h001,
		DPSM_SW_DISABLED = 9'h002,
		DPSM_READY = 9'h004,
		DPSM_IDENT = 9'h008,
		DPSM_SWITCHED_ON = 9'h010,
		DPSM_OP_ENABLE = 9'h020,
		DPSM_QUICK_STOP = 9'h040,
		DPSM_FAULT_REACT = 9'h080,
		DPSM_FAULT = 9'h100
	} dpsm_state_t;

	// status word state bits 0,1,2,3,5,6 packed as {6,5,3,2,1,0}
	localparam logic [5:0] DPSM_SW_NOT_READY = 6'h00;
	localparam logic [5:0] DPSM_SW_SW_DISABLED = 6'h20;
	localparam logic [5:0] DPSM_SW_READY = 6'h11;
	localparam logic [5:0] DPSM_SW_SWITCHED_ON = 6'h13;
	localparam logic [5:0] DPSM_SW_OP_ENABLE = 6'h17;
	localparam logic [5:0] DPSM_SW_QUICK_STOP = 6'h07;
	localparam logic [5:0] DPSM_SW_FAULT_REACT = 6'h0F;
	localparam logic [5:0] DPSM_SW_FAULT = 6'h08;

	// timing
	localparam int DPSM_CLK_HZ = 100_000_000;
	localparam int DPSM_IDENT_MS = 1000;
	localparam int DPSM_IDENT_CYC = DPSM_IDENT_MS * (DPSM_CLK_HZ / 1000);
	localparam int DPSM_INIT_CYC = 16;
endpackage

// ==== dpsm_timer.sv ====
// dpsm_timer: load-and-count-down delay timer
// assumes one clock; o_done pulses one cycle on expiry
`timescale 1ns/1ps
module dpsm_timer #(
	parameter int WIDTH = 32
) (
	// clock and reset
	input wire logic i_mclk,
	input wire logic i_rst_n,
	// control
	input wire logic i_start,
	input wire logic i_abort,
	input wire logic [WIDTH-1:0] i_count,
	// result
	output logic o_busy,
	output logic o_done
);
	logic [WIDTH-1:0] cnt_r; // cycles left

	initial begin
		if (WIDTH < 2) $error("dpsm_timer: WIDTH too small");
	end

	// count down while busy
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cnt_r <= '0;
			o_busy <= 1'b0;
			o_done <= 1'b0;
		end else begin
			o_done <= 1'b0;
			if (i_abort) begin
				o_busy <= 1'b0;
			end else if (i_start) begin
				cnt_r <= i_count;
				o_busy <= 1'b1;
			end else if (o_busy) begin
				if (cnt_r <= 1) begin
					o_busy <= 1'b0;
					o_done <= 1'b1;
				end else begin
					cnt_r <= cnt_r - 1'b1;
				end
			end
		end
	end
endmodule

// ==== dpsm_core.sv ====
// dpsm_core: power-stage state machine of a stepper drive
// assumes commands and events come from logic on i_mclk;
// i_standstill comes from the motion generator on the same clock
`timescale 1ns/1ps
module dpsm_core import dpsm_pkg::*; #(
	parameter int IDENT_CYC = DPSM_IDENT_CYC,
	parameter int INIT_CYC = DPSM_INIT_CYC
) (
	// clock and reset
	input wire logic i_mclk,
	input wire logic i_rst_n,
	// command port
	input wire logic i_cmd_valid,
	input wire logic [3:0] i_cmd,
	// events
	input wire logic i_error,
	input wire logic i_warning,
	input wire logic i_warn_reset,
	input wire logic i_standstill,
	// drive outputs
	output logic o_voltage_en,
	output logic o_motion_en,
	output logic o_brake,
	output logic o_ident_run,
	// status
	output logic [5:0] o_status_state,
	output logic o_status_warning,
	output logic o_status_volt
);
	dpsm_state_t state_r; // current state
	dpsm_state_t state_nxt; // next state
	logic [15:0] init_cnt_r; // startup init delay
	logic ident_done_r; // identification already done
	logic brake_pend_r; // disable operation braking
	logic id_start; // launch identification
	logic id_done; // identification finished
	logic id_busy; // identification running
	logic cmd_ok; // valid command this cycle

	initial begin
		if (IDENT_CYC < 1 || INIT_CYC < 1 || INIT_CYC > 65535)
			$error("dpsm_core: bad timing parameter");
	end

	// packed status code of a state
	function automatic logic [5:0] state_code(input dpsm_state_t s);
		case (s)
			DPSM_SW_DISABLED: state_code = DPSM_SW_SW_DISABLED;
			DPSM_READY: state_code = DPSM_SW_READY;
			DPSM_IDENT: state_code = DPSM_SW_READY;
			DPSM_SWITCHED_ON: state_code = DPSM_SW_SWITCHED_ON;
			DPSM_OP_ENABLE: state_code = DPSM_SW_OP_ENABLE;
			DPSM_QUICK_STOP: state_code = DPSM_SW_QUICK_STOP;
			DPSM_FAULT_REACT: state_code = DPSM_SW_FAULT_REACT;
			DPSM_FAULT: state_code = DPSM_SW_FAULT;
			default: state_code = DPSM_SW_NOT_READY;
		endcase
	endfunction

	// voltage applied in a state
	function automatic logic volt_of(input dpsm_state_t s);
		volt_of = (s == DPSM_IDENT) || (s == DPSM_SWITCHED_ON) ||
			(s == DPSM_OP_ENABLE) || (s == DPSM_QUICK_STOP);
	endfunction

	assign cmd_ok = i_cmd_valid;
	assign id_start = (state_r == DPSM_READY) && cmd_ok &&
		(i_cmd == DPSM_CMD_SWITCH_ON) && !ident_done_r && !i_error;

	// identification measurement timer
	dpsm_timer #(
		.WIDTH(32)
	) u_ident (
		.i_mclk(i_mclk),
		.i_rst_n(i_rst_n),
		.i_start(id_start),
		.i_abort(state_nxt != DPSM_IDENT && state_r == DPSM_IDENT),
		.i_count(32'(IDENT_CYC)),
		.o_busy(id_busy),
		.o_done(id_done)
	);

	// next state decision
	always_comb begin
		state_nxt = state_r;
		if (i_error && state_r != DPSM_FAULT &&
			state_r != DPSM_FAULT_REACT && state_r != DPSM_NOT_READY) begin
			state_nxt = DPSM_FAULT_REACT;
		end else begin
			case (state_r)
				DPSM_NOT_READY: begin
					if (init_cnt_r == 16'(INIT_CYC))
						state_nxt = DPSM_SW_DISABLED;
				end
				DPSM_SW_DISABLED: begin
					if (cmd_ok && i_cmd == DPSM_CMD_SHUTDOWN)
						state_nxt = DPSM_READY;
				end
				DPSM_READY: begin
					if (cmd_ok && (i_cmd == DPSM_CMD_DIS_VOLT ||
						i_cmd == DPSM_CMD_QUICK_STOP))
						state_nxt = DPSM_SW_DISABLED;
					else if (cmd_ok && i_cmd == DPSM_CMD_SWITCH_ON)
						state_nxt = ident_done_r ? DPSM_SWITCHED_ON :
							DPSM_IDENT;
				end
				DPSM_IDENT: begin
					if (id_done)
						state_nxt = DPSM_SWITCHED_ON;
				end
				DPSM_SWITCHED_ON: begin
					if (cmd_ok && (i_cmd == DPSM_CMD_DIS_VOLT ||
						i_cmd == DPSM_CMD_QUICK_STOP))
						state_nxt = DPSM_SW_DISABLED;
					else if (cmd_ok && i_cmd == DPSM_CMD_SHUTDOWN)
						state_nxt = DPSM_READY;
					else if (cmd_ok && i_cmd == DPSM_CMD_EN_OP &&
						!brake_pend_r)
						state_nxt = DPSM_OP_ENABLE;
				end
				DPSM_OP_ENABLE: begin
					if (cmd_ok && i_cmd == DPSM_CMD_DIS_OP)
						state_nxt = DPSM_SWITCHED_ON;
					else if (cmd_ok && i_cmd == DPSM_CMD_SHUTDOWN)
						state_nxt = DPSM_READY;
					else if (cmd_ok && i_cmd == DPSM_CMD_DIS_VOLT)
						state_nxt = DPSM_SW_DISABLED;
					else if (cmd_ok && i_cmd == DPSM_CMD_QUICK_STOP)
						state_nxt = DPSM_QUICK_STOP;
				end
				DPSM_QUICK_STOP: begin
					if (cmd_ok && i_cmd == DPSM_CMD_EN_OP)
						state_nxt = DPSM_OP_ENABLE;
					else if (i_standstill)
						state_nxt = DPSM_SW_DISABLED;
				end
				DPSM_FAULT_REACT: begin
					state_nxt = DPSM_FAULT; // voltage cut, then fault
				end
				DPSM_FAULT: begin
					if (cmd_ok && i_cmd == DPSM_CMD_FAULT_RESET)
						state_nxt = DPSM_SW_DISABLED;
				end
				default: state_nxt = DPSM_NOT_READY;
			endcase
		end
	end

	// state register, not ready at reset
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state_r <= DPSM_NOT_READY;
		end else begin
			state_r <= state_nxt;
		end
	end

	// internal initialization delay after start
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			init_cnt_r <= '0;
		end else if (state_r == DPSM_NOT_READY &&
			init_cnt_r != 16'(INIT_CYC)) begin
			init_cnt_r <= init_cnt_r + 16'h0001;
		end
	end

	// identification done once per module start
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ident_done_r <= 1'b0;
		end else if (state_r == DPSM_IDENT && id_done) begin
			ident_done_r <= 1'b1;
		end
	end

	// braking after disable operation until standstill
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			brake_pend_r <= 1'b0;
		end else if (state_r == DPSM_OP_ENABLE &&
			state_nxt == DPSM_SWITCHED_ON) begin
			brake_pend_r <= !i_standstill;
		end else if (i_standstill || state_nxt != DPSM_SWITCHED_ON) begin
			brake_pend_r <= 1'b0;
		end
	end

	// drive outputs, registered from the next state
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_voltage_en <= 1'b0;
			o_motion_en <= 1'b0;
			o_brake <= 1'b0;
			o_ident_run <= 1'b0;
			o_status_volt <= 1'b0;
			o_status_state <= DPSM_SW_NOT_READY;
		end else begin
			o_voltage_en <= volt_of(state_nxt);
			o_status_volt <= volt_of(state_nxt);
			o_motion_en <= (state_nxt == DPSM_OP_ENABLE);
			o_brake <= (state_nxt == DPSM_QUICK_STOP) ||
				(state_r == DPSM_OP_ENABLE &&
				state_nxt == DPSM_SWITCHED_ON && !i_standstill) ||
				(brake_pend_r && state_nxt == DPSM_SWITCHED_ON &&
				!i_standstill);
			o_ident_run <= (state_nxt == DPSM_IDENT);
			o_status_state <= state_code(state_nxt);
		end
	end

	// warning bit, set wins over reset
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_status_warning <= 1'b0;
		end else if (i_warning) begin
			o_status_warning <= 1'b1;
		end else if (i_warn_reset ||
			(state_r == DPSM_FAULT && state_nxt != DPSM_FAULT)) begin
			o_status_warning <= 1'b0;
		end
	end
endmodule

// ==== dpsm_core_monitor.sv ====
// dpsm_core_monitor: port assertions for dpsm_core
// assumes one clock, async low reset
`timescale 1ns/1ps
module dpsm_core_monitor import dpsm_pkg::*; #(
	parameter int IDENT_CYC = DPSM_IDENT_CYC
) (
	// clock and reset
	input wire logic i_mclk,
	input wire logic i_rst_n,
	// commands and events
	input wire logic i_cmd_valid,
	input wire logic [3:0] i_cmd,
	input wire logic i_error,
	// drive and status
	input wire logic o_voltage_en,
	input wire logic o_motion_en,
	input wire logic o_brake,
	input wire logic o_ident_run,
	input wire logic [5:0] o_status_state
);
	default clocking dc @(posedge i_mclk); endclocking
	default disable iff (!i_rst_n);
	// command taken with no fault racing it
	wire logic cv = i_cmd_valid && !i_error;
	wire logic [5:0] st = o_status_state;
	wire logic son = st == DPSM_SW_SWITCHED_ON;
	wire logic rdy = st == DPSM_SW_READY && !o_ident_run;
	// cycles of the running identification
	logic [31:0] id_cnt_r;
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			id_cnt_r <= '0;
		end else begin
			id_cnt_r <= o_ident_run ? id_cnt_r + 1 : '0;
		end
	end
	chk_motion_op_only: assert property (
		o_motion_en |-> st == DPSM_SW_OP_ENABLE) else $error("motion");
	chk_dis_to_ready: assert property (
		cv && i_cmd == 4'h1 && st == DPSM_SW_SW_DISABLED
		|=> rdy && !o_voltage_en) else $error("shutdown");
	chk_ready_to_dis: assert property (
		cv && rdy && (i_cmd == 4'h3 || i_cmd == 4'h4)
		|=> st == DPSM_SW_SW_DISABLED) else $error("ready off");
	chk_son_cut_volt: assert property (
		cv && son && (i_cmd == 4'h3 || i_cmd == 4'h4)
		|=> st == DPSM_SW_SW_DISABLED && !o_voltage_en) else $error("son off");
	chk_ident_length: assert property (
		$fell(o_ident_run) && st != DPSM_SW_FAULT_REACT |-> son
		&& id_cnt_r >= IDENT_CYC && id_cnt_r <= IDENT_CYC + 2)
		else $error("ident");
	chk_son_shutdown: assert property (
		cv && son && i_cmd == 4'h1 |=> rdy && !o_voltage_en)
		else $error("son shutdown");
	chk_enable_op: assert property (
		cv && son && !o_brake && i_cmd == 4'h6
		|=> st == DPSM_SW_OP_ENABLE && o_motion_en) else $error("enop");
	chk_disable_op: assert property (
		cv && st == DPSM_SW_OP_ENABLE && i_cmd == 4'h5
		|=> son && !o_motion_en && o_voltage_en) else $error("disop");
	chk_error_react: assert property (
		i_error && !(st inside {6'h00, 6'h0F, 6'h08})
		|=> st == DPSM_SW_FAULT_REACT && !o_voltage_en
		##1 st == DPSM_SW_FAULT) else $error("fault");
	chk_undef_hold: assert property (
		cv && (i_cmd == 4'h0 || i_cmd > 4'h7) && (rdy || son)
		|=> $stable(st) && $stable(o_voltage_en)) else $error("undef");
	// main scenarios reached
	cov_ident: cover property (o_ident_run);
	cov_brake: cover property (o_brake);
	cov_qstop: cover property (st == DPSM_SW_QUICK_STOP);
	cov_fault: cover property (st == DPSM_SW_FAULT);
endmodule
bind dpsm_core dpsm_core_monitor #(.IDENT_CYC(IDENT_CYC)) u_mon (
	.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_cmd_valid(i_cmd_valid),
	.i_cmd(i_cmd), .i_error(i_error), .o_voltage_en(o_voltage_en),
	.o_motion_en(o_motion_en), .o_brake(o_brake),
	.o_ident_run(o_ident_run), .o_status_state(o_status_state));

// ==== dpsm_app.sv ====
// dpsm_app: controlling application sending commands
// assumes the drive takes a command the edge after it rises
`timescale 1ns/1ps
module dpsm_app (
	// clock
	input wire logic i_mclk,
	// command port
	output logic o_cmd_valid,
	output logic [3:0] o_cmd
);
	initial begin
		o_cmd_valid = 1'b0;
		o_cmd = 4'h0;
	end
	// one-cycle strobe; code scrambled once released
	task automatic send(input logic [3:0] c);
		@(posedge i_mclk);
		o_cmd_valid <= 1'b1;
		o_cmd <= c;
		@(posedge i_mclk);
		o_cmd_valid <= 1'b0;
		o_cmd <= ~c;
	endtask
endmodule

// ==== tb_top.sv ====
// tb_top: scenario bench for dpsm_core
// assumes shortened identification and init counts
`timescale 1ns/1ps
module tb_top import dpsm_pkg::*; ;
	localparam int IC = 20;
	localparam int INIT = 4;
	logic i_mclk, i_rst_n, i_error, i_warning, i_warn_reset, i_standstill;
	logic cv, vo, mo, br, id, sw, sv;
	logic [3:0] cmd;
	logic [5:0] ss;
	int err_count = 0;
	int check_count = 0;
	dpsm_app app (.i_mclk(i_mclk), .o_cmd_valid(cv), .o_cmd(cmd));
	dpsm_core #(.IDENT_CYC(IC), .INIT_CYC(INIT)) dut (
		.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_cmd_valid(cv), .i_cmd(cmd),
		.i_error(i_error), .i_warning(i_warning),
		.i_warn_reset(i_warn_reset), .i_standstill(i_standstill),
		.o_voltage_en(vo), .o_motion_en(mo), .o_brake(br),
		.o_ident_run(id), .o_status_state(ss),
		.o_status_warning(sw), .o_status_volt(sv));
	task automatic ck(input logic [5:0] g, input logic [5:0] e, string m);
		check_count++;
		if (g !== e) begin
			err_count++;
			$display("[FAIL] %0t %s", $time, m);
		end
	endtask
	// state plus flags {volt,motion,brake,ident}
	task automatic st(input logic [5:0] s, input logic [5:0] f, string m);
		ck(ss, s, m);
		ck({2'b00, vo, mo, br, id}, f, m);
		ck({5'h00, sv}, {5'h00, f[3]}, m);
	endtask
	task automatic go(input logic [3:0] c);
		app.send(c);
		#1;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge i_mclk);
		#1;
	endtask
	task automatic t_power();
		tick(INIT - 1);
		st(DPSM_SW_NOT_READY, 6'h00, "init");
		tick(3);
		st(DPSM_SW_SW_DISABLED, 6'h00, "auto");
		go(4'hF);
		go(DPSM_CMD_DIS_VOLT);
		st(DPSM_SW_SW_DISABLED, 6'h00, "undef");
		go(DPSM_CMD_SHUTDOWN);
		st(DPSM_SW_READY, 6'h00, "ready");
		go(4'h0);
		st(DPSM_SW_READY, 6'h00, "undef rdy");
		go(DPSM_CMD_SWITCH_ON);
		st(DPSM_SW_READY, 6'h09, "ident");
		go(DPSM_CMD_EN_OP);
		tick(IC - 4);
		st(DPSM_SW_READY, 6'h09, "ident on");
		tick(6);
		st(DPSM_SW_SWITCHED_ON, 6'h08, "son");
		go(DPSM_CMD_SHUTDOWN);
		st(DPSM_SW_READY, 6'h00, "son off");
		go(DPSM_CMD_SWITCH_ON);
		st(DPSM_SW_SWITCHED_ON, 6'h08, "no ident");
		go(4'h9);
		st(DPSM_SW_SWITCHED_ON, 6'h08, "undef son");
		$display("t_power done");
	endtask
	task automatic t_op();
		go(DPSM_CMD_EN_OP);
		st(DPSM_SW_OP_ENABLE, 6'h0C, "enop");
		go(DPSM_CMD_DIS_OP);
		go(DPSM_CMD_EN_OP);
		st(DPSM_SW_SWITCHED_ON, 6'h0A, "brake");
		@(posedge i_mclk) i_standstill <= 1'b1;
		tick(2);
		st(DPSM_SW_SWITCHED_ON, 6'h08, "still");
		go(DPSM_CMD_QUICK_STOP);
		st(DPSM_SW_SW_DISABLED, 6'h00, "qs son");
		go(DPSM_CMD_SHUTDOWN);
		go(DPSM_CMD_QUICK_STOP);
		st(DPSM_SW_SW_DISABLED, 6'h00, "qs rdy");
		go(DPSM_CMD_SHUTDOWN);
		go(DPSM_CMD_DIS_VOLT);
		st(DPSM_SW_SW_DISABLED, 6'h00, "dv rdy");
		go(DPSM_CMD_SHUTDOWN);
		go(DPSM_CMD_SWITCH_ON);
		go(DPSM_CMD_DIS_VOLT);
		st(DPSM_SW_SW_DISABLED, 6'h00, "dv son");
		// leaving operation enable by shutdown and disable voltage
		go(DPSM_CMD_SHUTDOWN);
		go(DPSM_CMD_SWITCH_ON);
		go(DPSM_CMD_EN_OP);
		go(DPSM_CMD_SHUTDOWN);
		st(DPSM_SW_READY, 6'h00, "op shut");
		go(DPSM_CMD_SWITCH_ON);
		go(DPSM_CMD_EN_OP);
		go(DPSM_CMD_DIS_VOLT);
		st(DPSM_SW_SW_DISABLED, 6'h00, "op dv");
		$display("t_op done");
	endtask
	task automatic t_qstop_fault();
		go(DPSM_CMD_SHUTDOWN);
		go(DPSM_CMD_SWITCH_ON);
		go(DPSM_CMD_EN_OP);
		@(posedge i_mclk) i_standstill <= 1'b0;
		go(DPSM_CMD_QUICK_STOP);
		tick(4);
		ck(ss, DPSM_SW_QUICK_STOP, "qs");
		ck({5'h00, mo}, 6'h00, "qs mo");
		// back to operation enable while still decelerating
		go(DPSM_CMD_EN_OP);
		st(DPSM_SW_OP_ENABLE, 6'h0C, "qs back");
		go(DPSM_CMD_QUICK_STOP);
		st(DPSM_SW_QUICK_STOP, 6'h0A, "qs again");
		@(posedge i_mclk) i_standstill <= 1'b1;
		tick(2);
		ck(ss, DPSM_SW_SW_DISABLED, "qs end");
		go(DPSM_CMD_SHUTDOWN);
		go(DPSM_CMD_SWITCH_ON);
		@(posedge i_mclk) i_warning <= 1'b1;
		@(posedge i_mclk) i_warning <= 1'b0;
		tick(1);
		ck({sw, ss[4:0]}, 6'h33, "warn");
		@(posedge i_mclk) i_warn_reset <= 1'b1;
		@(posedge i_mclk) i_warn_reset <= 1'b0;
		tick(1);
		ck({5'h00, sw}, 6'h00, "warn clr");
		@(posedge i_mclk) i_error <= 1'b1;
		tick(1);
		ck({vo, ss[4:0]}, 6'h0F, "react");
		tick(1);
		ck(ss, DPSM_SW_FAULT, "fault");
		@(posedge i_mclk) i_error <= 1'b0;
		go(DPSM_CMD_FAULT_RESET);
		ck(ss, DPSM_SW_SW_DISABLED, "freset");
		$display("t_qstop_fault done");
	endtask
	// mid-run restart: init again, identification runs again
	task automatic t_restart();
		@(posedge i_mclk) i_rst_n <= 1'b0;
		tick(2);
		st(DPSM_SW_NOT_READY, 6'h00, "rst");
		@(posedge i_mclk) i_rst_n <= 1'b1;
		tick(INIT + 1);
		st(DPSM_SW_SW_DISABLED, 6'h00, "rst auto");
		go(DPSM_CMD_SHUTDOWN);
		go(DPSM_CMD_SWITCH_ON);
		st(DPSM_SW_READY, 6'h09, "reident");
		tick(IC + 2);
		st(DPSM_SW_SWITCHED_ON, 6'h08, "reident end");
		$display("t_restart done");
	endtask
	task automatic final_report();
		$display("checks %0d errors %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	initial begin
		i_mclk = 1'b0;
		forever #5 i_mclk = ~i_mclk;
	end
	initial begin
		{i_rst_n, i_error, i_warning, i_warn_reset, i_standstill} = '0;
		repeat (4) @(posedge i_mclk);
		i_rst_n <= 1'b1;
		t_power();
		t_op();
		t_qstop_fault();
		t_restart();
		final_report();
	end
	initial begin
		#20000;
		err_count++;
		$display("[FAIL] %0t watchdog", $time);
		final_report();
	end
endmodule
